// >>> logic/opmode_pkg.sv
package opmode_pkg;
	localparam logic [4:0] OFF_STATE_CODE = 5'h14;
	localparam logic [4:0] SLEEP_CODE = 5'h0A;
	localparam logic [4:0] ACTIVE_CODE = 5'h05;
	localparam logic [15:0] INTERVAL_RESET = 16'h0000;
	localparam logic [1:0] CAUSE_POWER_ON = 2'h0;
	localparam logic [1:0] CAUSE_COMMAND = 2'h1;
	localparam logic [1:0] CAUSE_TIMEOUT = 2'h2;
	localparam logic [1:0] CAUSE_FAULT = 2'h3;
	localparam int CYCLIC_TICK_NS = 1000;
	localparam int CLK_PERIOD_NS = 4;
	localparam int CYCLIC_TICK_CYCLES = CYCLIC_TICK_NS / CLK_PERIOD_NS;
	typedef enum logic [3:0] {
		ST_OFF = 4'b0001,
		ST_LOW = 4'b0010,
		ST_ACTIVE = 4'b0100,
		ST_CYCLIC = 4'b1000
	} op_state_e;
endpackage

// >>> logic/operation_mode_controller.sv
`timescale 1ns/1ps
module operation_mode_controller import opmode_pkg::*; #(
	parameter int TICK_CYCLES = CYCLIC_TICK_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic target_write_in,
	input wire logic [4:0] target_state_field_in,
	input wire logic [15:0] cyclic_wake_interval_in,
	input wire logic bus_activity_in,
	input wire logic wake_event_in,
	input wire logic fatal_fault_in,
	input wire logic comm_timeout_in,
	input wire logic timeout_to_reset_in,
	input wire logic meas_busy_in,
	input wire logic meas_done_in,
	input wire logic limit_violation_in,
	input wire logic host_meas_enable_in,
	output logic [3:0] operating_state_register_out,
	output logic [1:0] reset_cause_register_out,
	output logic meas_abort_out,
	output logic results_invalidate_out,
	output logic self_test_start_out,
	output logic measurement_enable_bit_out,
	output logic conversion_allowed_out,
	output logic balancing_allowed_out,
	output logic wipe_volatile_out,
	output logic wipe_low_power_out
);
	// refuse a tick count that the prescaler cannot serve
	if (TICK_CYCLES < 1) begin : g_bad_tick
		$error("tick count must be at least one");
	end

	typedef struct packed {
		op_state_e state;
		op_state_e prev;
		logic [1:0] cause;
		logic [31:0] tick;
		logic [15:0] interval_cnt;
		logic abort;
		logic invalidate;
		logic bist;
		logic meas_en;
		logic conv_ok;
		logic bal_ok;
		logic wipe_all;
		logic wipe_low;
	} state_s;

	state_s cur;
	state_s next_cur;
	// synchronised pins; first stage only feeds the second
	logic [1:0] bus_sync;
	logic [1:0] wake_sync;

	// -------------------------------------------------------------
	// pin synchronisers
	// -------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bus_sync <= 2'h0;
			wake_sync <= 2'h0;
		end else begin
			bus_sync <= {bus_sync[0], bus_activity_in};
			wake_sync <= {wake_sync[0], wake_event_in};
		end
	end

	// -------------------------------------------------------------
	// next-state logic
	// -------------------------------------------------------------
	// pulses drop each cycle; a transition raises for one cycle the ones that fit its goal state, and abort only while busy
	always_comb begin
		op_state_e goal;
		logic go;
		goal = cur.state;
		go = 1'b0;
		next_cur = cur;
		next_cur.abort = 1'b0;
		next_cur.invalidate = 1'b0;
		next_cur.bist = 1'b0;
		next_cur.wipe_all = 1'b0;
		next_cur.wipe_low = 1'b0;
		if (fatal_fault_in) begin
			goal = ST_OFF;
			go = 1'b1;
			next_cur.cause = CAUSE_FAULT;
		end else if (comm_timeout_in && cur.state != ST_OFF) begin
			go = 1'b1;
			if (timeout_to_reset_in) begin
				goal = ST_OFF;
				next_cur.cause = CAUSE_TIMEOUT;
			end else begin
				goal = cur.prev;
			end
		end else begin
			case (cur.state)
				ST_OFF: begin
					// only host activity wakes; wake pins ignored here
					if (bus_sync[1]) begin
						goal = ST_ACTIVE;
						go = 1'b1;
					end
				end
				ST_LOW: begin
					// monitors wake sources, no conversion here
					if (wake_sync[1]) begin
						goal = ST_ACTIVE;
						go = 1'b1;
					end else if (cyclic_wake_interval_in != INTERVAL_RESET) begin
						if (cur.tick >= TICK_CYCLES - 1) begin
							next_cur.tick = 32'h0;
							if (cur.interval_cnt >= cyclic_wake_interval_in - 16'h1) begin
								goal = ST_CYCLIC;
								go = 1'b1;
							end else begin
								next_cur.interval_cnt = cur.interval_cnt + 16'h1;
							end
						end else begin
							next_cur.tick = cur.tick + 32'h1;
						end
					end // zero interval: wait for a command
				end
				ST_CYCLIC: begin
					// one measurement, then limit check or synchronised wake pin decides
					if (meas_done_in) begin
						goal = (limit_violation_in || wake_sync[1]) ? ST_ACTIVE : ST_LOW;
						go = 1'b1;
					end
				end
				ST_ACTIVE: begin
				end
				default: begin
					goal = ST_OFF;
					go = 1'b1;
				end
			endcase
			if (target_write_in && cur.state != ST_OFF) begin
				case (target_state_field_in)
					OFF_STATE_CODE: begin
						goal = ST_OFF;
						go = 1'b1;
						next_cur.cause = CAUSE_COMMAND;
					end
					SLEEP_CODE: begin
						goal = ST_LOW;
						go = 1'b1;
					end
					ACTIVE_CODE: begin
						goal = ST_ACTIVE;
						go = 1'b1;
					end
					default: begin
					end
				endcase
			end
		end
		if (go && goal != cur.state) begin
			next_cur.prev = cur.state;
			next_cur.state = goal;
			next_cur.tick = 32'h0;
			next_cur.interval_cnt = 16'h0;
			next_cur.abort = meas_busy_in;
			next_cur.wipe_all = (goal == ST_OFF);
			next_cur.wipe_low = (goal == ST_LOW);
			next_cur.invalidate = (goal == ST_ACTIVE);
			next_cur.bist = (goal == ST_ACTIVE);
		end
		next_cur.conv_ok = (next_cur.state == ST_ACTIVE) || (next_cur.state == ST_CYCLIC);
		next_cur.bal_ok = (next_cur.state != ST_OFF);
		// the enable follows the state being entered, so it lands with the state itself;
		// host writes to the enable are ignored outside active mode
		case (next_cur.state)
			ST_CYCLIC: next_cur.meas_en = 1'b1;
			ST_ACTIVE: next_cur.meas_en = host_meas_enable_in;
			default: next_cur.meas_en = 1'b0;
		endcase
	end

	// -------------------------------------------------------------
	// state register
	// -------------------------------------------------------------
	// reset lands in off with wipe raised
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cur <= '{state: ST_OFF, prev: ST_OFF, cause: CAUSE_POWER_ON, tick: 32'h0,
				interval_cnt: 16'h0, abort: 1'b0, invalidate: 1'b0,
				bist: 1'b0, meas_en: 1'b0, conv_ok: 1'b0, bal_ok: 1'b0, wipe_all: 1'b1,
				wipe_low: 1'b0};
		end else begin
			cur <= next_cur;
		end
	end

	assign operating_state_register_out = cur.state;
	assign reset_cause_register_out = cur.cause;
	assign meas_abort_out = cur.abort;
	assign results_invalidate_out = cur.invalidate;
	assign self_test_start_out = cur.bist;
	assign measurement_enable_bit_out = cur.meas_en;
	assign conversion_allowed_out = cur.conv_ok;
	assign balancing_allowed_out = cur.bal_ok;
	assign wipe_volatile_out = cur.wipe_all;
	assign wipe_low_power_out = cur.wipe_low;

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	property p_active_entry;
		@(posedge clk_in) disable iff (!rst_b_in)
		(cur.state == ST_ACTIVE && $past(cur.state) != ST_ACTIVE) |-> results_invalidate_out && self_test_start_out;
	endproperty
	a_active_entry: assert property (p_active_entry) else $error("active entry missing pulses");
	property p_off_wipe;
		@(posedge clk_in) disable iff (!rst_b_in)
		(cur.state == ST_OFF && $past(cur.state) != ST_OFF) |-> wipe_volatile_out;
	endproperty
	a_off_wipe: assert property (p_off_wipe) else $error("off entry without wipe");
	property p_off_stays;
		@(posedge clk_in) disable iff (!rst_b_in)
		(cur.state == ST_OFF && !bus_sync[1] && !fatal_fault_in) |=> cur.state == ST_OFF;
	endproperty
	a_off_stays: assert property (p_off_stays) else $error("off left without bus activity");
	property p_low_noconv;
		@(posedge clk_in) disable iff (!rst_b_in)
		cur.state == ST_LOW |-> !conversion_allowed_out && balancing_allowed_out;
	endproperty
	a_low_noconv: assert property (p_low_noconv) else $error("conversion in low power");
	property p_cyclic_meas;
		@(posedge clk_in) disable iff (!rst_b_in)
		cur.state == ST_CYCLIC |-> measurement_enable_bit_out;
	endproperty
	a_cyclic_meas: assert property (p_cyclic_meas) else $error("cyclic measure enable low");
	property p_zero_interval;
		@(posedge clk_in) disable iff (!rst_b_in)
		(cur.state == ST_LOW && cyclic_wake_interval_in == 16'h0) |=> cur.state != ST_CYCLIC;
	endproperty
	a_zero_interval: assert property (p_zero_interval) else $error("cyclic with zero interval");
	property p_bad_code;
		@(posedge clk_in) disable iff (!rst_b_in)
		(target_write_in && target_state_field_in == 5'h1F && !fatal_fault_in && !comm_timeout_in
		 && cur.state == ST_ACTIVE) |=> cur.state == ST_ACTIVE;
	endproperty
	a_bad_code: assert property (p_bad_code) else $error("undefined code changed state");
	property p_fault;
		@(posedge clk_in) disable iff (!rst_b_in)
		fatal_fault_in |=> cur.state == ST_OFF && reset_cause_register_out == CAUSE_FAULT;
	endproperty
	a_fault: assert property (p_fault) else $error("fault did not reset");

	// -------------------------------------------------------------
	// command and event checks
	// -------------------------------------------------------------
	// a clean sleep request from active mode, nothing stronger in the same cycle
	sequence s_sleep_cmd;
		target_write_in && target_state_field_in == SLEEP_CODE && !fatal_fault_in
			&& !comm_timeout_in && cur.state == ST_ACTIVE;
	endsequence
	// low power entered with the partial wipe pulse
	sequence s_low_entry;
		cur.state == ST_LOW && wipe_low_power_out;
	endsequence
	property p_sleep_cmd;
		@(posedge clk_in) disable iff (!rst_b_in)
		s_sleep_cmd |=> s_low_entry;
	endproperty
	a_sleep_cmd: assert property (p_sleep_cmd) else $error("sleep code not obeyed");
	// off code from active lands in off and records a command cause
	property p_off_cmd;
		@(posedge clk_in) disable iff (!rst_b_in)
		(target_write_in && target_state_field_in == OFF_STATE_CODE && !fatal_fault_in
		 && !comm_timeout_in && cur.state == ST_ACTIVE)
		|=> cur.state == ST_OFF && reset_cause_register_out == CAUSE_COMMAND;
	endproperty
	a_off_cmd: assert property (p_off_cmd) else $error("off code not obeyed");
	// every state change carries the abort request of a busy measurement
	property p_abort;
		@(posedge clk_in) disable iff (!rst_b_in)
		$changed(cur.state) |-> meas_abort_out == $past(meas_busy_in);
	endproperty
	a_abort: assert property (p_abort) else $error("abort not raised on change");
	// timeout configured to go back returns to the state before the last change
	property p_tmo_prev;
		@(posedge clk_in) disable iff (!rst_b_in)
		(comm_timeout_in && !timeout_to_reset_in && !fatal_fault_in && cur.state != ST_OFF)
		|=> cur.state == $past(cur.prev);
	endproperty
	a_tmo_prev: assert property (p_tmo_prev) else $error("timeout did not go back");
	// timeout configured to reset ends in off with a timeout cause
	property p_tmo_reset;
		@(posedge clk_in) disable iff (!rst_b_in)
		(comm_timeout_in && timeout_to_reset_in && !fatal_fault_in && cur.state != ST_OFF)
		|=> cur.state == ST_OFF && reset_cause_register_out == CAUSE_TIMEOUT;
	endproperty
	a_tmo_reset: assert property (p_tmo_reset) else $error("timeout did not reset");
	// synchronised bus activity wakes the off state in one cycle
	property p_bus_wake;
		@(posedge clk_in) disable iff (!rst_b_in)
		(cur.state == ST_OFF && bus_sync[1] && !fatal_fault_in) |=> cur.state == ST_ACTIVE;
	endproperty
	a_bus_wake: assert property (p_bus_wake) else $error("bus activity did not wake");
	// a wake event in low power brings the block to active
	property p_wake_low;
		@(posedge clk_in) disable iff (!rst_b_in)
		(cur.state == ST_LOW && wake_sync[1] && !fatal_fault_in && !comm_timeout_in
		 && !target_write_in) |=> cur.state == ST_ACTIVE;
	endproperty
	a_wake_low: assert property (p_wake_low) else $error("wake event ignored");
	// the end of the cyclic measurement decides between sleeping and waking
	sequence s_cyclic_done;
		cur.state == ST_CYCLIC && meas_done_in && !fatal_fault_in && !comm_timeout_in
			&& !target_write_in;
	endsequence
	property p_cyclic_done;
		@(posedge clk_in) disable iff (!rst_b_in)
		s_cyclic_done |=> cur.state == (($past(limit_violation_in) || $past(wake_sync[1]))
			? ST_ACTIVE : ST_LOW);
	endproperty
	a_cyclic_done: assert property (p_cyclic_done) else $error("cyclic exit wrong");
	// the last unit of the interval expiring moves low power to cyclic
	property p_cyclic_entry;
		@(posedge clk_in) disable iff (!rst_b_in)
		(cur.state == ST_LOW && cyclic_wake_interval_in != INTERVAL_RESET
		 && cur.tick >= TICK_CYCLES - 1 && cur.interval_cnt >= cyclic_wake_interval_in - 16'h1
		 && !wake_sync[1] && !fatal_fault_in && !comm_timeout_in && !target_write_in)
		|=> cur.state == ST_CYCLIC;
	endproperty
	a_cyclic_entry: assert property (p_cyclic_entry) else $error("cyclic not entered");
	// the off state runs nothing at all
	property p_off_quiet;
		@(posedge clk_in) disable iff (!rst_b_in)
		cur.state == ST_OFF |-> !balancing_allowed_out && !conversion_allowed_out
			&& !measurement_enable_bit_out;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("off state not quiet");
endmodule

// >>> dv/host_link_model.sv
`timescale 1ns/1ps
// ------------------------------
// host side: turns a send request into one target field write
// ------------------------------
module host_link_model (
	input wire logic clk_in,
	input wire logic send_in,
	input wire logic [4:0] code_in,
	output logic target_write_out,
	output logic [4:0] target_state_field_out
);
	// one message carries only the target field, never other registers
	always_ff @(posedge clk_in) begin
		target_write_out <= send_in;
		target_state_field_out <= send_in ? code_in : ~target_state_field_out;
	end
endmodule

// >>> dv/operation_mode_controller_test.sv
`timescale 1ns/1ps
module operation_mode_controller_test import opmode_pkg::*;;
	logic clk_in = 0, rst_b_in = 0, send = 0, bus_act = 0, wake = 0, fault = 0, tmo = 0;
	logic to_rst = 0, busy = 0, done = 0, viol = 0, hmeas = 1, twr;
	logic [4:0] code = 5'h00, tfield;
	logic [15:0] interval = 16'h0000;
	logic [3:0] st;
	logic [1:0] cause;
	logic abrt, inv, bist, men, conv, bal, wv, wl;
	int err_count = 0, comparisons = 0, inv_n = 0, bist_n = 0;
	typedef struct {logic [4:0] c; logic [3:0] s;} row_s;
	row_s rows [4] = '{'{5'h0A, ST_LOW}, '{5'h05, ST_ACTIVE}, '{5'h1F, ST_ACTIVE},
		'{5'h14, ST_OFF}};
	initial forever #2 clk_in = ~clk_in;
	host_link_model host (.clk_in(clk_in), .send_in(send), .code_in(code),
		.target_write_out(twr), .target_state_field_out(tfield));
	operation_mode_controller #(.TICK_CYCLES(2)) dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.target_write_in(twr), .target_state_field_in(tfield),
		.cyclic_wake_interval_in(interval), .bus_activity_in(bus_act), .wake_event_in(wake),
		.fatal_fault_in(fault), .comm_timeout_in(tmo), .timeout_to_reset_in(to_rst),
		.meas_busy_in(busy), .meas_done_in(done), .limit_violation_in(viol),
		.host_meas_enable_in(hmeas), .operating_state_register_out(st),
		.reset_cause_register_out(cause), .meas_abort_out(abrt),
		.results_invalidate_out(inv), .self_test_start_out(bist),
		.measurement_enable_bit_out(men), .conversion_allowed_out(conv),
		.balancing_allowed_out(bal), .wipe_volatile_out(wv), .wipe_low_power_out(wl));
	// entry pulses are one cycle wide, so count them on every edge
	always @(posedge clk_in) begin
		if (inv === 1'b1) inv_n++;
		if (bist === 1'b1) bist_n++;
	end
	// ------------------------------
	// shared tasks
	// ------------------------------
	task automatic step(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// bounded wait: a hang counts as a mismatch and closes the run
	task automatic wait_state(input logic [3:0] s);
		for (int i = 0; i < 20 && st !== s; i++) step(1);
		check("state", 16'(st), 16'(s));
		if (st !== s) complete_run();
	endtask
	task automatic send_code(input logic [4:0] c);
		send = 1;
		code = c;
		step(1);
		send = 0;
		step(3);
	endtask
	task automatic wake_up;
		bus_act = 1;
		wait_state(ST_ACTIVE);
		bus_act = 0;
		step(3);
	endtask
	// ------------------------------
	// main sequence
	// ------------------------------
	initial begin
		step(4);
		check("state_in_reset", 16'(st), 16'(ST_OFF));
		check("wipe_in_reset", 16'(wv), 16'h0001);
		rst_b_in = 1;
		wake = 1;
		step(8);
		check("off_ignores_wake", 16'(st), 16'(ST_OFF));
		wake = 0;
		send_code(5'h0A);
		check("off_refuses_write", 16'(st), 16'(ST_OFF));
		inv_n = 0;
		bist_n = 0;
		wake_up();
		check("invalidate_pulses", 16'(inv_n), 16'h0001);
		check("self_test_pulses", 16'(bist_n), 16'h0001);
		foreach (rows[i]) begin
			send_code(rows[i].c);
			wait_state(rows[i].s);
			if (rows[i].s === ST_LOW) begin
				check("conv_low", 16'(conv), 16'h0000);
				check("bal_low", 16'(bal), 16'h0001);
			end
		end
		check("cause_command", 16'(cause), 16'(CAUSE_COMMAND));
		// low power with zero interval must not wander off
		wake_up();
		send_code(5'h0A);
		step(30);
		check("stay_low", 16'(st), 16'(ST_LOW));
		// cyclic round with a clean result, then one with a violation
		interval = 16'h0001;
		for (int k = 0; k < 2; k++) begin
			wait_state(ST_CYCLIC);
			check("meas_en_cyclic", 16'(men), 16'h0001);
			viol = (k == 1);
			done = 1;
			step(1);
			done = 0;
			viol = 0;
			wait_state(k == 1 ? ST_ACTIVE : ST_LOW);
		end
		interval = 16'h0000;
		to_rst = 1;
		tmo = 1;
		step(1);
		tmo = 0;
		wait_state(ST_OFF);
		check("cause_timeout", 16'(cause), 16'(CAUSE_TIMEOUT));
		wake_up();
		fault = 1;
		tmo = 1;
		step(1);
		fault = 0;
		tmo = 0;
		wait_state(ST_OFF);
		check("cause_fault", 16'(cause), 16'(CAUSE_FAULT));
		// sleep while a measurement runs, then a timeout that goes back
		wake_up();
		busy = 1;
		send = 1;
		code = SLEEP_CODE;
		step(1);
		send = 0;
		step(1);
		check("abort_on_sleep", 16'(abrt), 16'h0001);
		check("wipe_low_entry", 16'(wl), 16'h0001);
		busy = 0;
		to_rst = 0;
		tmo = 1;
		step(1);
		tmo = 0;
		check("timeout_previous", 16'(st), 16'(ST_ACTIVE));
		complete_run();
	end
endmodule
